// [rtl/slem_cfg.svh]
// Constants of the serial link error monitor: offsets, fields, resets, times.
// Assumes a 250 MHz clock and a same-clock character receiver in front.
`ifndef SLEM_CFG_SVH
`define SLEM_CFG_SVH

`define SLEM_OFS_CTRL 8'h00
`define SLEM_OFS_RX_PERIOD 8'h04
`define SLEM_OFS_STATUS 8'h08
`define SLEM_OFS_IRQ_STAT 8'h0C
`define SLEM_OFS_IRQ_MASK 8'h10
`define SLEM_OFS_ALARM_CLR 8'h14
`define SLEM_OFS_REC_COUNT 8'h18
`define SLEM_OFS_REC_DATA 8'h1C

`define SLEM_CTRL_CNT_LSB 0
`define SLEM_CTRL_TOA_LSB 4
`define SLEM_CTRL_STA_LSB 6
`define SLEM_CTRL_RST 8'h03
`define SLEM_RX_PERIOD_RST 16'h0000

`define SLEM_IRQ_LINK_ERR 0
`define SLEM_IRQ_LINK_ALARM 1
`define SLEM_IRQ_TIMEOUT 2
`define SLEM_IRQ_NACK 3

`define SLEM_CODE_LINK 8'h84
`define SLEM_CODE_TIMEOUT 8'h85

`define SLEM_CLK_MHZ 250
`define SLEM_RX_MON_US 10
`define SLEM_TICK_US 1000
`define SLEM_BLINK_MS 250

`endif

// [rtl/slem_monitor.sv]
// Link error supervision: frame checks, warning, alarms, record, registers.
// Assumes characters arrive from a receiver on the same clock.
//
// The implementer's own choices: the plain strobed port and the address map.
`include "slem_cfg.svh"

module slem_monitor #(
  parameter int REC_DEPTH = 8,
  parameter int TICK_CYCLES = `SLEM_TICK_US * `SLEM_CLK_MHZ
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Received characters
  input wire logic char_valid_in,
  input wire logic [7:0] char_data_in,
  input wire logic char_stop_bit_in,
  input wire logic char_first_in,
  input wire logic char_last_in,
  input wire logic sim_send_in,
  // Command side
  input wire logic nack_in,
  input wire logic [7:0] nack_code_in,
  input wire logic stop_req_in,
  // Frame results
  output logic frame_accept_out,
  output logic frame_discard_out,
  // Drive and indicators
  output logic fault_indicator_out,
  output logic caution_indicator_out,
  output logic alarm_lamp_out,
  output logic motor_stop_out,
  output logic motor_excite_out,
  output slem_pkg::slem_stop_mode_type stop_mode_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Derived counts
  // ----------------------------------------------------------------
  localparam int RX_MON_CYC = `SLEM_RX_MON_US * `SLEM_CLK_MHZ;
  localparam int MON_W = $clog2(RX_MON_CYC + 1);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int IDX_W = $clog2(REC_DEPTH);
  localparam int BLINK_TICKS = `SLEM_BLINK_MS * 1000 / `SLEM_TICK_US;

  if (REC_DEPTH < 2 || (REC_DEPTH & (REC_DEPTH - 1)) != 0) begin : g_chk_d
    $error("REC_DEPTH must be a power of two of at least 2");
  end
  if (TICK_CYCLES < 2) begin : g_chk_t
    $error("TICK_CYCLES must be at least 2");
  end
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] o);
    is_addr = (a == o);
  endfunction : is_addr

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  slem_pkg::slem_rx_state_type rx_state;
  slem_pkg::slem_rx_state_type next_rx_state;
  logic [MON_W-1:0] mon_cnt;
  logic [MON_W-1:0] next_mon_cnt;
  logic [7:0] bcc;
  logic [7:0] next_bcc;
  logic [7:0] ctrl;
  logic [15:0] rx_period;
  logic [3:0] consec;
  logic [3:0] next_consec;
  logic link_alarm;
  logic next_link_alarm;
  logic warning;
  logic timeout_alarm;
  logic next_timeout_alarm;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic [15:0] idle_ticks;
  logic [15:0] blink_cnt;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [3:0] next_irq_stat;
  logic [11:0] rec [REC_DEPTH];
  logic [IDX_W-1:0] rec_wptr;
  logic [IDX_W:0] rec_count;
  logic [IDX_W-1:0] rec_idx;

  // ----------------------------------------------------------------
  // Frame checking
  // ----------------------------------------------------------------
  logic ch;
  logic mon_expire;
  logic err;
  logic ok;
  slem_pkg::slem_cause_type cause;
  logic alarm_clr;
  logic next_alarm_any;
  logic alarm_any;

  assign alarm_clr = reg_write_in && reg_wdata_in[0] &&
                     is_addr(reg_addr_in, `SLEM_OFS_ALARM_CLR);
  assign ch = char_valid_in && !link_alarm;
  assign mon_expire = (rx_state == slem_pkg::SLEM_RECV) &&
                      (mon_cnt >= MON_W'(RX_MON_CYC - 1));
  assign alarm_any = link_alarm || timeout_alarm;

  always_comb begin
    next_rx_state = rx_state;
    next_mon_cnt = mon_cnt;
    next_bcc = bcc;
    err = 1'b0;
    ok = 1'b0;
    cause = 4'h0;
    case (rx_state)
      slem_pkg::SLEM_IDLE: begin
        if (ch && char_first_in) begin
          next_mon_cnt = '0;
          next_bcc = char_data_in;
          if (!char_stop_bit_in) begin
            err = 1'b1;
            cause = 4'h1;
          end else if (sim_send_in && char_data_in != 8'h00) begin
            err = 1'b1;
            cause = 4'h8;
          end else begin
            next_rx_state = slem_pkg::SLEM_RECV;
          end
        end
      end
      slem_pkg::SLEM_RECV: begin
        next_mon_cnt = mon_cnt + MON_W'(1);
        if (link_alarm) begin
          next_rx_state = slem_pkg::SLEM_IDLE;
        end else if (mon_expire) begin
          err = 1'b1;
          cause = 4'h2;
          next_rx_state = slem_pkg::SLEM_IDLE;
        end else if (ch) begin
          if (!char_stop_bit_in) begin
            err = 1'b1;
            cause = 4'h1;
            next_rx_state = slem_pkg::SLEM_IDLE;
          end else if (char_last_in) begin
            next_rx_state = slem_pkg::SLEM_IDLE;
            if (char_data_in != bcc) begin
              err = 1'b1;
              cause = 4'h4;
            end else begin
              ok = 1'b1;
            end
          end else begin
            next_bcc = bcc ^ char_data_in;
          end
        end
      end
      default: begin
        next_rx_state = slem_pkg::SLEM_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rx_state <= slem_pkg::SLEM_IDLE;
      mon_cnt <= '0;
      bcc <= 8'h00;
    end else begin
      rx_state <= next_rx_state;
      mon_cnt <= next_mon_cnt;
      bcc <= next_bcc;
    end
  end

  // ----------------------------------------------------------------
  // Error counting, warning and link alarm
  // ----------------------------------------------------------------
  always_comb begin
    next_consec = consec;
    if (ok || alarm_clr) begin
      next_consec = 4'h0;
    end
    if (err && consec != 4'hF) begin
      next_consec = consec + 4'h1;
    end
    next_link_alarm = link_alarm && !alarm_clr;
    if (err && next_consec >= ctrl[`SLEM_CTRL_CNT_LSB +: 4]) begin
      next_link_alarm = 1'b1;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      consec <= 4'h0;
      link_alarm <= 1'b0;
    end else begin
      consec <= next_consec;
      link_alarm <= next_link_alarm;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      warning <= 1'b0;
    end else if (err) begin
      warning <= 1'b1;
    end else if (ok) begin
      warning <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Communication timeout
  // ----------------------------------------------------------------
  assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge clock_in) begin
    if (!resetn_in || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  always_comb begin
    next_timeout_alarm = timeout_alarm && !alarm_clr;
    if (rx_period != 16'h0000 && idle_ticks >= rx_period) begin
      next_timeout_alarm = 1'b1;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      idle_ticks <= 16'h0000;
      timeout_alarm <= 1'b0;
    end else begin
      timeout_alarm <= next_timeout_alarm;
      if (ch || alarm_any) begin
        idle_ticks <= 16'h0000;
      end else if (tick && idle_ticks != 16'hFFFF) begin
        idle_ticks <= idle_ticks + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Drive and indicator outputs
  // ----------------------------------------------------------------
  assign next_alarm_any = next_link_alarm || next_timeout_alarm;
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      fault_indicator_out <= 1'b1;
      caution_indicator_out <= 1'b0;
      motor_stop_out <= 1'b0;
      motor_excite_out <= 1'b1;
      frame_accept_out <= 1'b0;
      frame_discard_out <= 1'b0;
    end else begin
      fault_indicator_out <= !next_alarm_any;
      motor_stop_out <= next_alarm_any || stop_req_in;
      caution_indicator_out <= err || (warning && !ok);
      motor_excite_out <= !next_link_alarm;
      frame_accept_out <= ok;
      frame_discard_out <= err || nack_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      stop_mode_out <= 2'h0;
    end else if (next_timeout_alarm && !timeout_alarm) begin
      stop_mode_out <= ctrl[`SLEM_CTRL_TOA_LSB +: 2];
    end else if (stop_req_in) begin
      stop_mode_out <= ctrl[`SLEM_CTRL_STA_LSB +: 2];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      alarm_lamp_out <= 1'b0;
      blink_cnt <= 16'h0000;
    end else if (!next_alarm_any) begin
      alarm_lamp_out <= 1'b0;
      blink_cnt <= 16'h0000;
    end else if (!alarm_any) begin
      alarm_lamp_out <= 1'b1;
      blink_cnt <= 16'h0000;
    end else if (tick) begin
      if (blink_cnt == 16'(BLINK_TICKS - 1)) begin
        blink_cnt <= 16'h0000;
        alarm_lamp_out <= !alarm_lamp_out;
      end else begin
        blink_cnt <= blink_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Communication error record
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rec_wptr <= '0;
      rec_count <= '0;
    end else if (err || nack_in) begin
      rec_wptr <= rec_wptr + IDX_W'(1);
      if (rec_count != (IDX_W + 1)'(REC_DEPTH)) begin
        rec_count <= rec_count + (IDX_W + 1)'(1);
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < REC_DEPTH; i++) begin
        rec[i] <= 12'h000;
      end
    end else if (err) begin
      rec[rec_wptr] <= {cause, `SLEM_CODE_LINK};
    end else if (nack_in) begin
      rec[rec_wptr] <= {4'h0, nack_code_in};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    next_irq_stat = irq_stat;
    if (reg_write_in && is_addr(reg_addr_in, `SLEM_OFS_IRQ_STAT)) begin
      next_irq_stat = irq_stat & ~reg_wdata_in[3:0];
    end
    if (err) begin
      next_irq_stat[`SLEM_IRQ_LINK_ERR] = 1'b1;
    end
    if (next_link_alarm && !link_alarm) begin
      next_irq_stat[`SLEM_IRQ_LINK_ALARM] = 1'b1;
    end
    if (next_timeout_alarm && !timeout_alarm) begin
      next_irq_stat[`SLEM_IRQ_TIMEOUT] = 1'b1;
    end
    if (nack_in) begin
      next_irq_stat[`SLEM_IRQ_NACK] = 1'b1;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      irq_stat <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_out <= |(next_irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ctrl <= `SLEM_CTRL_RST;
      rx_period <= `SLEM_RX_PERIOD_RST;
      irq_mask <= 4'h0;
      rec_idx <= '0;
    end else if (reg_write_in) begin
      if (is_addr(reg_addr_in, `SLEM_OFS_CTRL)) begin
        ctrl <= reg_wdata_in[7:0];
      end
      if (is_addr(reg_addr_in, `SLEM_OFS_RX_PERIOD)) begin
        rx_period <= reg_wdata_in[15:0];
      end
      if (is_addr(reg_addr_in, `SLEM_OFS_IRQ_MASK)) begin
        irq_mask <= reg_wdata_in[3:0];
      end
      if (is_addr(reg_addr_in, `SLEM_OFS_REC_DATA)) begin
        rec_idx <= reg_wdata_in[IDX_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!resetn_in || !reg_read_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      case (reg_addr_in)
        `SLEM_OFS_CTRL: reg_rdata_out <= {24'h00_0000, ctrl};
        `SLEM_OFS_RX_PERIOD: reg_rdata_out <= {16'h0000, rx_period};
        `SLEM_OFS_STATUS: reg_rdata_out <= {24'h00_0000, consec, 1'b0,
          timeout_alarm, link_alarm, warning};
        `SLEM_OFS_IRQ_STAT: reg_rdata_out <= {28'h000_0000, irq_stat};
        `SLEM_OFS_IRQ_MASK: reg_rdata_out <= {28'h000_0000, irq_mask};
        `SLEM_OFS_REC_COUNT: reg_rdata_out <= 32'(rec_count);
        `SLEM_OFS_REC_DATA: reg_rdata_out <= {20'h0_0000, rec[rec_idx]};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule : slem_monitor

// [rtl/slem_pkg.sv]
// Types of the serial link error monitor.
// Assumes nothing of its surroundings.
package slem_pkg;

  typedef enum logic [0:0] {
    SLEM_IDLE,
    SLEM_RECV
  } slem_rx_state_type;

  typedef logic [1:0] slem_stop_mode_type;

  typedef logic [3:0] slem_cause_type;

endpackage : slem_pkg

// [verification/slem_chk_monitor.sv]
// Port checker of the serial link error monitor.
// Assumes it is bound to slem_monitor and sees only its ports.
module slem_chk (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Watched ports
  input wire logic char_valid_in,
  input wire logic [7:0] char_data_in,
  input wire logic char_stop_bit_in,
  input wire logic char_first_in,
  input wire logic sim_send_in,
  input wire logic nack_in,
  input wire logic frame_accept_out,
  input wire logic frame_discard_out,
  input wire logic fault_indicator_out,
  input wire logic caution_indicator_out,
  input wire logic alarm_lamp_out,
  input wire logic motor_stop_out,
  input wire logic motor_excite_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------------------------------
  // Frame openings that must be refused
  // ----------------------------------------------------------------
  sequence s_bad_stop;
    char_valid_in && char_first_in && !char_stop_bit_in && motor_excite_out;
  endsequence
  sequence s_bad_head;
    char_valid_in && char_first_in && char_stop_bit_in && sim_send_in &&
      char_data_in != 8'h00 && motor_excite_out;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_framing_drop: assert property (s_bad_stop |=> frame_discard_out)
    else $error("zero stop bit not discarded");
  chk_header_drop: assert property (s_bad_head |=> frame_discard_out)
    else $error("bad broadcast address not discarded");
  chk_one_result: assert property (
    !(frame_accept_out && frame_discard_out))
    else $error("frame both accepted and discarded");
  chk_warn_raise: assert property (
    frame_discard_out && !$past(nack_in) |-> caution_indicator_out)
    else $error("link error without caution");
  chk_warn_clear: assert property (
    frame_accept_out |=> !caution_indicator_out || frame_discard_out)
    else $error("caution kept after good frame");
  chk_alarm_onset: assert property (
    $fell(fault_indicator_out) |-> alarm_lamp_out && motor_stop_out)
    else $error("alarm onset without lamp and stop");
  chk_alarm_hold: assert property (
    !fault_indicator_out |-> motor_stop_out)
    else $error("motor not stopped during alarm");
  chk_link_excite: assert property (
    !motor_excite_out |-> !fault_indicator_out)
    else $error("excitation removed without alarm");
  chk_rx_halted: assert property (
    !motor_excite_out && char_valid_in |=> !frame_accept_out)
    else $error("frame accepted during link alarm");
endmodule : slem_chk

bind slem_monitor slem_chk chk_u (.clock_in, .resetn_in, .char_valid_in,
  .char_data_in, .char_stop_bit_in, .char_first_in, .sim_send_in, .nack_in,
  .frame_accept_out, .frame_discard_out, .fault_indicator_out,
  .caution_indicator_out, .alarm_lamp_out, .motor_stop_out, .motor_excite_out);

// [verification/slem_host_model.sv]
// Host side of the link: sends one frame per go pulse.
// Assumes the bench holds the frame fields steady while busy.
module slem_host_model #(
  parameter int RESEND_GAP = 2600
) (
  // Clock and command
  input wire logic clock_in,
  input wire logic go_in,
  input wire logic [7:0] addr_in,
  input wire logic [3:0] len_in,
  input wire logic [3:0] bad_in,
  input wire logic bcc_in,
  input wire logic sim_in,
  input wire logic cut_in,
  input wire logic [3:0] gap_in,
  // Characters
  output logic char_valid_out,
  output logic [7:0] char_data_out,
  output logic char_stop_bit_out,
  output logic char_first_out,
  output logic char_last_out,
  output logic sim_send_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bcc;
  logic [7:0] d;
  int i;
  task automatic drop;
    char_valid_out <= 1'h0;
    char_first_out <= 1'h0;
    char_last_out <= 1'h0;
    sim_send_out <= 1'h0;
    char_data_out <= ~d;
  endtask : drop
  initial begin
    d = 8'h00;
    busy_out = 1'h0;
    char_stop_bit_out = 1'h1;
    drop();
  end
  always begin
    @(posedge clock_in);
    if (go_in) begin
      busy_out <= 1'h1;
      bcc = 8'h00;
      for (i = 0; i < len_in && !(cut_in && i == len_in - 1); i++) begin
        d = (i == 0) ? addr_in : 8'h10 + 8'(i);
        if (i == len_in - 1) d = bcc ^ {7'h00, bcc_in};
        bcc = bcc ^ d;
        char_valid_out <= 1'h1;
        char_data_out <= d;
        char_first_out <= (i == 0);
        char_last_out <= (i == len_in - 1);
        sim_send_out <= sim_in && i == 0;
        char_stop_bit_out <= (i != bad_in);
        @(posedge clock_in);
        if (gap_in != 4'h0) begin
          drop();
          repeat (gap_in) @(posedge clock_in);
        end
      end
      drop();
      repeat (RESEND_GAP) @(posedge clock_in);
      busy_out <= 1'h0;
    end
  end
endmodule : slem_host_model

// [verification/tb_top.sv]
// Self-checking bench of the serial link error monitor.
// Assumes the host model drives characters; 250 MHz clock.
`include "slem_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] addr;
    logic [3:0] len;
    logic [3:0] bad;
    logic bcc;
    logic sim;
    logic cut;
    logic [3:0] gap;
    logic acc;
    logic [7:0] stat;
  } slem_row_type;
  slem_row_type rows [10] = '{
    '{8'h05, 4'h3, 4'hF, 1'h0, 1'h0, 1'h0, 4'h0, 1'h1, 8'h00},
    '{8'h05, 4'h4, 4'hF, 1'h1, 1'h0, 1'h0, 4'h1, 1'h0, 8'h11},
    '{8'h07, 4'h2, 4'hF, 1'h0, 1'h0, 1'h0, 4'h2, 1'h1, 8'h00},
    '{8'h05, 4'h3, 4'h1, 1'h0, 1'h0, 1'h0, 4'h0, 1'h0, 8'h11},
    '{8'h03, 4'h3, 4'hF, 1'h0, 1'h1, 1'h0, 4'h0, 1'h0, 8'h21},
    '{8'h00, 4'h3, 4'hF, 1'h0, 1'h1, 1'h0, 4'h3, 1'h1, 8'h00},
    '{8'h05, 4'h4, 4'hF, 1'h0, 1'h0, 1'h1, 4'h0, 1'h0, 8'h11},
    '{8'h05, 4'h5, 4'hF, 1'h0, 1'h0, 1'h0, 4'h1, 1'h1, 8'h00},
    '{8'h05, 4'h3, 4'h0, 1'h0, 1'h0, 1'h0, 4'h0, 1'h0, 8'h11},
    '{8'h09, 4'h2, 4'hF, 1'h0, 1'h0, 1'h0, 4'h0, 1'h1, 8'h00}};
  logic [31:0] rec_exp [5] = '{32'h484, 32'h184, 32'h884, 32'h284,
    32'h184};
  slem_row_type cur;
  logic clock_in, resetn_in, reg_write_in, reg_read_in, go, busy;
  logic [7:0] reg_addr_in, char_data_in, nack_code_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, d, acc_n, dis_n;
  logic char_valid_in, char_stop_bit_in, char_first_in, char_last_in;
  logic sim_send_in, nack_in, stop_req_in, frame_accept_out, irq_out;
  logic frame_discard_out, fault_indicator_out, caution_indicator_out;
  logic alarm_lamp_out, motor_stop_out, motor_excite_out;
  slem_pkg::slem_stop_mode_type stop_mode_out;
  int err_count, checks_done, k;

  slem_monitor #(.TICK_CYCLES(20)) dut_u (.clock_in, .resetn_in,
    .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
    .char_valid_in, .char_data_in, .char_stop_bit_in, .char_first_in,
    .char_last_in, .sim_send_in, .nack_in, .nack_code_in, .stop_req_in,
    .frame_accept_out, .frame_discard_out, .fault_indicator_out,
    .caution_indicator_out, .alarm_lamp_out, .motor_stop_out,
    .motor_excite_out, .stop_mode_out, .irq_out);
  slem_host_model #(.RESEND_GAP(2600)) host_u (.clock_in, .go_in(go),
    .addr_in(cur.addr), .len_in(cur.len), .bad_in(cur.bad), .bcc_in(cur.bcc),
    .sim_in(cur.sim), .cut_in(cur.cut), .gap_in(cur.gap),
    .char_valid_out(char_valid_in), .char_data_out(char_data_in),
    .char_stop_bit_out(char_stop_bit_in), .char_first_out(char_first_in),
    .char_last_out(char_last_in), .sim_send_out(sim_send_in),
    .busy_out(busy));

  always #2 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (frame_accept_out === 1'h1) acc_n++;
    if (frame_discard_out === 1'h1) dis_n++;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic reg_wr(logic [7:0] a, logic [31:0] v);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_write_in <= 1'h1;
    @(posedge clock_in);
    reg_write_in <= 1'h0;
  endtask : reg_wr
  task automatic reg_rd(logic [7:0] a);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'h1;
    @(posedge clock_in);
    reg_read_in <= 1'h0;
    #1 d = reg_rdata_out;
  endtask : reg_rd
  task automatic send(slem_row_type r);
    acc_n = 0;
    dis_n = 0;
    @(posedge clock_in);
    cur <= r;
    go <= 1'h1;
    @(posedge clock_in);
    go <= 1'h0;
    #1;
    for (k = 0; busy && k < 4000; k++) @(posedge clock_in);
    chk("host busy", 32'h0, {31'h0, busy});
    if (busy) give_verdict();
  endtask : send
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clock_in, resetn_in, reg_write_in, reg_read_in, go} = 5'h00;
    {nack_in, stop_req_in, reg_addr_in, nack_code_in} = 18'h00000;
    {reg_wdata_in, err_count, checks_done, acc_n, dis_n} = 0;
    cur = rows[0];
    repeat (4) @(posedge clock_in);
    resetn_in <= 1'h1;
    #1 chk("idle outputs", 32'hC0, {fault_indicator_out, motor_excite_out,
      caution_indicator_out, alarm_lamp_out, motor_stop_out,
      frame_accept_out, frame_discard_out, irq_out});
    reg_rd(`SLEM_OFS_CTRL);
    chk("ctrl reset", 32'h3, d);
    reg_rd(`SLEM_OFS_RX_PERIOD);
    chk("period reset", 32'h0, d);
    reg_rd(8'h40);
    chk("unmapped", 32'h0, d);
    $display("reset test done");
    foreach (rows[r]) begin
      send(rows[r]);
      chk("accepts", {31'h0, rows[r].acc}, acc_n);
      chk("discards", {31'h0, ~rows[r].acc}, dis_n);
      reg_rd(`SLEM_OFS_STATUS);
      chk("status", {24'h0, rows[r].stat}, d);
      chk("caution", {31'h0, rows[r].stat[0]}, caution_indicator_out);
      $display("row %0d done", r);
    end
    reg_rd(`SLEM_OFS_REC_COUNT);
    chk("record count", 32'h5, d);
    for (int i = 0; i < 5; i++) begin
      reg_wr(`SLEM_OFS_REC_DATA, i);
      reg_rd(`SLEM_OFS_REC_DATA);
      chk("record entry", rec_exp[i], d);
    end
    reg_rd(`SLEM_OFS_IRQ_STAT);
    chk("irq status", 32'h1, d);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    reg_wr(`SLEM_OFS_IRQ_MASK, 32'hF);
    reg_rd(`SLEM_OFS_IRQ_MASK);
    chk("irq raised", 32'h1, {31'h0, irq_out});
    reg_wr(`SLEM_OFS_IRQ_STAT, 32'h1);
    reg_rd(`SLEM_OFS_IRQ_STAT);
    chk("irq cleared", 32'h0, {31'h0, irq_out});
    dis_n = 0;
    @(posedge clock_in);
    nack_in <= 1'h1;
    nack_code_in <= 8'h88;
    @(posedge clock_in);
    nack_in <= 1'h0;
    reg_rd(`SLEM_OFS_IRQ_STAT);
    chk("nack discard", 32'h1, dis_n);
    chk("nack irq", 32'h8, d);
    $display("record and irq test done");
    reg_wr(`SLEM_OFS_CTRL, 32'h02);
    send(rows[1]);
    chk("one error", 32'h1, {31'h0, fault_indicator_out});
    send(rows[1]);
    chk("alarm drive", 32'h6, {fault_indicator_out, alarm_lamp_out,
      motor_stop_out, motor_excite_out});
    reg_rd(`SLEM_OFS_STATUS);
    chk("alarm status", 32'h23, d);
    send(rows[0]);
    chk("halted rx", 32'h0, acc_n);
    reg_wr(`SLEM_OFS_ALARM_CLR, 32'h1);
    reg_rd(`SLEM_OFS_STATUS);
    chk("alarm cleared", 32'h3, {30'h0, fault_indicator_out,
      motor_excite_out});
    $display("link alarm test done");
    reg_wr(`SLEM_OFS_CTRL, 32'h23);
    reg_wr(`SLEM_OFS_RX_PERIOD, 32'h3);
    for (k = 0; fault_indicator_out && k < 300; k++) @(posedge clock_in);
    #1 chk("timeout", 32'h6, {fault_indicator_out, motor_excite_out,
      stop_mode_out});
    if (fault_indicator_out) give_verdict();
    reg_wr(`SLEM_OFS_RX_PERIOD, 32'h0);
    reg_wr(`SLEM_OFS_ALARM_CLR, 32'h1);
    reg_wr(`SLEM_OFS_CTRL, 32'h43);
    @(posedge clock_in);
    stop_req_in <= 1'h1;
    @(posedge clock_in);
    stop_req_in <= 1'h0;
    #1 chk("stop request", 32'hD, {fault_indicator_out, motor_stop_out,
      stop_mode_out});
    $display("timeout and stop test done");
    give_verdict();
  end
endmodule : tb_top
